//--- rcs_pkg.sv
// Shared constants for the radio configuration serial link
package rcs_pkg;
   // Header byte layout
   localparam int HDR_RW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam int ADDR_W = 6;
   localparam logic [7:0] RW_READ = 8'h01;
   // Status byte layout
   localparam int STAT_RDY_BIT = 7;
   localparam logic [7:0] STAT_RESET = 8'h80;
   // Register space
   localparam int REG_COUNT = 64;
   localparam logic [7:0] REG_RESET = 8'h00;
   // System clock
   localparam int CLK_PERIOD_NS = 10;
   // Serial clock half period for the host divider (10 ns cycles)
   localparam int SCLK_HALF_CYC = 8;
   // Pause between bytes in nanoseconds
   localparam int BYTE_GAP_NS = 100;
   localparam int BYTE_GAP_CYC = (BYTE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Power-down wait before first clock edge, microseconds
   localparam int PD_WAIT_US = 150;
   localparam int PD_WAIT_CYC = (PD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Crystal start-up time modelled in the device, microseconds
   localparam int XTAL_START_US = 100;
   localparam int XTAL_START_CYC = (XTAL_START_US * 1000) / CLK_PERIOD_NS;
   // FIFO depth
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 8;
endpackage : rcs_pkg

//--- rcs_link_if.sv
// Four-wire serial link between host and device ends
`timescale 1ns/1ps
interface rcs_link_if;
   logic chip_select_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe;
   // Serial output floats high when the device is not driving
   wire miso_line = miso_oe ? miso : 1'b1;
   modport device (input chip_select_n, input sclk, input mosi, output miso, output miso_oe);
   modport host (output chip_select_n, output sclk, output mosi, input miso_line);
endinterface : rcs_link_if

//--- rcs_fifo.sv
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module rcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // Flow control and pointers
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   // Storage has no reset; only written entries are read
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : rcs_fifo

//--- rcs_device.sv
// Device end: serial slave with register file and status byte
// What the datasheet requires of the link
// - Slave only, every byte MSB first
// - Header is rw, burst, six-bit address
// - Chip select high mid-byte aborts transfer
// - Host waits for low output before clocking
// - Awake device drives output low immediately
// - Reset loads defaults; host rewrites differing registers
// - 10 MHz allowed only with 100 ns gaps
// - No gaps: 9 MHz single, 6.5 burst
// - Blind host waits 150 us from power-down
// - Ready bit high until crystal stable
// - Read flag one reads, zero writes
`timescale 1ns/1ps
module rcs_device
   import rcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   rcs_link_if.device link,
   input wire logic sleep_req,
   input wire logic [2:0] chip_state,
   input wire logic [3:0] fifo_bytes,
   output logic crystal_ready_n,
   output logic crystal_off_state,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic overrun
);
   typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} rcs_dev_st_t;

   // Two-stage synchronisers for the pins
   logic [1:0] cs_s_q, sck_s_q, si_s_q;
   logic cs_q, sck_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cs_s_q <= 2'h3;
         sck_s_q <= 2'h0;
         si_s_q <= 2'h0;
         cs_q <= 1'b1;
         sck_q <= 1'b0;
      end else begin
         cs_s_q <= {cs_s_q[0], link.chip_select_n};
         sck_s_q <= {sck_s_q[0], link.sclk};
         si_s_q <= {si_s_q[0], link.mosi};
         cs_q <= cs_s_q[1];
         sck_q <= sck_s_q[1];
      end
   end
   logic cs_n, rise, fall, cs_fall;
   assign cs_n = cs_s_q[1];
   assign rise = sck_s_q[1] && !sck_q;
   assign fall = !sck_s_q[1] && sck_q;
   assign cs_fall = !cs_n && cs_q;

   // Crystal model: sleep stops it, chip select wakes it
   logic xtal_on_q, xtal_on_d;
   logic [$clog2(XTAL_START_CYC+1)-1:0] xcnt_q, xcnt_d;
   always_comb begin
      xtal_on_d = xtal_on_q;
      xcnt_d = xcnt_q;
      if (sleep_req && cs_n) begin
         xtal_on_d = 1'b0;
         xcnt_d = '0;
      end else if (!xtal_on_q && !cs_n) begin
         xcnt_d = xcnt_q + 1'b1;
         if (xcnt_q == ($bits(xcnt_q))'(XTAL_START_CYC - 1)) begin
            xtal_on_d = 1'b1;
         end
      end
   end

   // Shifter state
   rcs_dev_st_t st_q, st_d;
   logic [7:0] sr_q, sr_d, tx_q, tx_d;
   logic [2:0] bit_q, bit_d;
   logic rw_q, rw_d, burst_q, burst_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [7:0] regs_q [REG_COUNT];
   logic wr_en;
   logic [7:0] wr_val, byte_in, status;
   logic push;

   assign byte_in = {sr_q[6:0], si_s_q[1]};
   assign status = {!xtal_on_q, chip_state, fifo_bytes};

   always_comb begin
      st_d = st_q;
      sr_d = sr_q;
      tx_d = tx_q;
      bit_d = bit_q;
      rw_d = rw_q;
      burst_d = burst_q;
      addr_d = addr_q;
      wr_en = 1'b0;
      wr_val = byte_in;
      push = 1'b0;
      if (cs_n) begin
         st_d = ST_IDLE;
         bit_d = '0;
      end else if (cs_fall || (st_q == ST_IDLE && xtal_on_q)) begin
         if (xtal_on_q) begin
            st_d = ST_HDR;
            tx_d = status;
            bit_d = '0;
         end
      end else if (st_q != ST_IDLE && rise) begin
         sr_d = byte_in;
         bit_d = bit_q + 1'b1;
         if (bit_q == 3'h7) begin
            if (st_q == ST_HDR) begin
               rw_d = byte_in[HDR_RW_BIT];
               burst_d = byte_in[HDR_BURST_BIT];
               addr_d = byte_in[ADDR_W-1:0];
               st_d = ST_DATA;
               tx_d = byte_in[HDR_RW_BIT] ? regs_q[byte_in[ADDR_W-1:0]] : status;
            end else begin
               if (!rw_q) begin
                  wr_en = 1'b1;
                  push = 1'b1;
               end
               addr_d = burst_q ? addr_q + 1'b1 : addr_q;
               tx_d = rw_q ? regs_q[burst_q ? addr_q + 1'b1 : addr_q] : status;
            end
         end
      end else if (st_q != ST_IDLE && fall) begin
         if (bit_q != 3'h0) begin
            tx_d = {tx_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (wr_en) begin
         regs_q[addr_q] <= wr_val;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         sr_q <= '0;
         tx_q <= STAT_RESET;
         bit_q <= '0;
         rw_q <= 1'b0;
         burst_q <= 1'b0;
         addr_q <= '0;
         xtal_on_q <= 1'b1;
         xcnt_q <= '0;
      end else begin
         st_q <= st_d;
         sr_q <= sr_d;
         tx_q <= tx_d;
         bit_q <= bit_d;
         rw_q <= rw_d;
         burst_q <= burst_d;
         addr_q <= addr_d;
         xtal_on_q <= xtal_on_d;
         xcnt_q <= xcnt_d;
      end
   end

   // Written data bytes leave through the FIFO
   logic f_ready, f_valid;
   logic [7:0] f_data;
   rcs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(byte_in),
      .in_valid(push),
      .in_ready(f_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(rx_ready && !rx_valid)
   );

   // Registered outputs; output high while idle, driven while selected
   logic miso_q, oe_q, ovr_q;
   logic miso_d;
   always_comb begin
      miso_d = miso_q;
      if (st_d == ST_IDLE) begin
         miso_d = 1'b1;
      end else if (st_q == ST_IDLE || fall) begin
         // New byte loads on the eighth rise, shows only after the fall
         miso_d = tx_d[STAT_RDY_BIT];
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         miso_q <= 1'b1;
         oe_q <= 1'b0;
         ovr_q <= 1'b0;
         rx_data <= '0;
         rx_valid <= 1'b0;
         crystal_ready_n <= 1'b0;
         crystal_off_state <= 1'b0;
      end else begin
         miso_q <= miso_d;
         oe_q <= !cs_n;
         // Sticky drop flag: register writes never stall
         ovr_q <= ovr_q || (push && !f_ready);
         if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
         end else if (f_valid && rx_ready && !rx_valid) begin
            rx_valid <= 1'b1;
            rx_data <= f_data;
         end
         crystal_ready_n <= !xtal_on_q;
         crystal_off_state <= !xtal_on_q;
      end
   end
   assign link.miso = miso_q;
   assign link.miso_oe = oe_q;
   assign overrun = ovr_q;
endmodule : rcs_device

//--- rcs_host.sv
// Host end: serial master issuing header plus data transfers
`timescale 1ns/1ps
module rcs_host
   import rcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   rcs_link_if.host link,
   input wire logic req_valid,
   input wire logic [7:0] req_header,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   output logic req_ready,
   output logic [7:0] rsp_data,
   output logic rsp_valid,
   output logic busy
);
   typedef enum logic [2:0] {H_IDLE, H_WAIT, H_SHIFT, H_GAP, H_NEXT} rcs_host_st_t;

   // Two-stage synchroniser on serial input
   logic [1:0] so_s_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         so_s_q <= 2'h3;
      end else begin
         so_s_q <= {so_s_q[0], link.miso_line};
      end
   end

   rcs_host_st_t st_q, st_d;
   logic [7:0] sh_q, sh_d, in_q, in_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] div_q, div_d;
   logic sck_q, sck_d, cs_q, cs_d, hdr_q, hdr_d, last_q, last_d;
   logic rdy_d, rv_d;
   logic [7:0] rd_d;
   logic [$clog2(PD_WAIT_CYC+1)-1:0] wt_q, wt_d;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      in_d = in_q;
      bit_d = bit_q;
      div_d = div_q;
      sck_d = sck_q;
      cs_d = cs_q;
      hdr_d = hdr_q;
      last_d = last_q;
      wt_d = wt_q;
      rdy_d = 1'b0;
      rv_d = 1'b0;
      rd_d = rsp_data;
      case (st_q)
         H_IDLE: begin
            if (req_valid) begin
               cs_d = 1'b0;
               sh_d = req_header;
               hdr_d = 1'b1;
               wt_d = '0;
               st_d = H_WAIT;
            end
         end
         H_WAIT: begin
            wt_d = wt_q + 1'b1;
            if (!so_s_q[1] || wt_q == ($bits(wt_q))'(PD_WAIT_CYC)) begin
               st_d = H_SHIFT;
               div_d = '0;
               bit_d = '0;
            end
         end
         H_SHIFT: begin
            div_d = div_q + 1'b1;
            if (div_q == 8'(SCLK_HALF_CYC - 1)) begin
               div_d = '0;
               sck_d = !sck_q;
               if (!sck_q) begin
                  in_d = {in_q[6:0], so_s_q[1]};
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  bit_d = bit_q + 1'b1;
                  if (bit_q == 3'h7) begin
                     st_d = H_GAP;
                     wt_d = '0;
                  end
               end
            end
         end
         H_GAP: begin
            wt_d = wt_q + 1'b1;
            if (wt_q == ($bits(wt_q))'(BYTE_GAP_CYC)) begin
               rv_d = !hdr_q;
               rd_d = in_q;
               if (!hdr_q && last_q) begin
                  cs_d = 1'b1;
                  st_d = H_IDLE;
                  rdy_d = 1'b1;
               end else begin
                  st_d = H_NEXT;
               end
            end
         end
         H_NEXT: begin
            sh_d = req_data;
            last_d = req_last;
            // Every take is announced, so the user can present the next byte
            rdy_d = 1'b1;
            hdr_d = 1'b0;
            st_d = H_SHIFT;
            bit_d = '0;
            div_d = '0;
         end
         default: st_d = H_IDLE;
      endcase
   end

   // Serial pins come straight from flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= H_IDLE;
         sh_q <= '0;
         in_q <= '0;
         bit_q <= '0;
         div_q <= '0;
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         hdr_q <= 1'b0;
         last_q <= 1'b0;
         wt_q <= '0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         busy <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         in_q <= in_d;
         bit_q <= bit_d;
         div_q <= div_d;
         sck_q <= sck_d;
         cs_q <= cs_d;
         hdr_q <= hdr_d;
         last_q <= last_d;
         wt_q <= wt_d;
         req_ready <= rdy_d;
         rsp_valid <= rv_d;
         rsp_data <= rd_d;
         busy <= (st_d != H_IDLE);
      end
   end
   assign link.chip_select_n = cs_q;
   assign link.sclk = sck_q;
   assign link.mosi = sh_q[7];
endmodule : rcs_host

//--- rcs_link_monitor.sv
// Protocol checker on the serial link between the host and device ends
`timescale 1ns/1ps
module rcs_link_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_line,
   input wire logic crystal_ready_n
);
   logic sclk_q, sclk_d, rdy_q, rdy_d;
   logic [2:0] bits_q, bits_d;
   logic [4:0] gap_q, gap_d;
   default clocking mcb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Bits per frame and rise spacing; spacing saturates so idle reads as long
   always_comb begin
      sclk_d = sclk;
      bits_d = bits_q;
      rdy_d = rdy_q | !miso_line;
      gap_d = (gap_q == 5'h1f) ? gap_q : gap_q + 5'h01;
      if (sclk && !sclk_q) begin
         bits_d = bits_q + 3'h1;
         gap_d = 5'h00;
      end
      if (chip_select_n) begin
         bits_d = 3'h0;
         rdy_d = 1'b0;
      end
   end
   // Helper registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         bits_q <= 3'h0;
         rdy_q <= 1'b0;
         gap_q <= 5'h1f;
      end else begin
         sclk_q <= sclk_d;
         bits_q <= bits_d;
         rdy_q <= rdy_d;
         gap_q <= gap_d;
      end
   end
   property p_idle_low; chip_select_n |-> !sclk; endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock while deselected");
   property p_whole_byte; $rose(chip_select_n) |-> bits_q == 3'h0; endproperty
   a_whole_byte: assert property (p_whole_byte) else $error("deselect mid byte");
   property p_wait_rdy; $rose(sclk) |-> rdy_q; endproperty
   a_wait_rdy: assert property (p_wait_rdy) else $error("clock before ready");
   property p_wake; $fell(chip_select_n) && !crystal_ready_n |-> ##[1:6] !miso_line; endproperty
   a_wake: assert property (p_wake) else $error("ready output late");
   property p_not_rdy;
      !chip_select_n && crystal_ready_n && $past(crystal_ready_n) |-> miso_line;
   endproperty
   a_not_rdy: assert property (p_not_rdy) else $error("ready before crystal");
   property p_out_edge; !chip_select_n && $changed(miso_line) |-> !sclk; endproperty
   a_out_edge: assert property (p_out_edge) else $error("output moved while high");
   property p_in_hold; sclk |-> $stable(mosi); endproperty
   a_in_hold: assert property (p_in_hold) else $error("input moved while high");
   property p_clk_high; $rose(sclk) |-> sclk [*5]; endproperty
   a_clk_high: assert property (p_clk_high) else $error("clock high too short");
   property p_clk_low; $fell(sclk) |-> !sclk [*5]; endproperty
   a_clk_low: assert property (p_clk_low) else $error("clock low too short");
   property p_rate; $rose(sclk) && gap_q != 5'h1f |-> gap_q >= 5'h0f; endproperty
   a_rate: assert property (p_rate) else $error("clock too fast");
   c_frame: cover property ($rose(chip_select_n) && bits_q == 3'h0);
   c_wake: cover property ($fell(crystal_ready_n));
   c_low_bit: cover property (!chip_select_n && sclk && !miso_line);
endmodule : rcs_link_monitor

//--- tb.sv
// Bench joining host and device ends, with a model of registers and FIFO
`timescale 1ns/1ps
module tb;
   import rcs_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sleep_req = 1'b0;
   logic req_valid = 1'b0;
   logic req_last = 1'b0;
   logic stall = 1'b0;
   logic rx_ready = 1'b0;
   logic [2:0] chip_state = 3'h0;
   logic [3:0] fifo_bytes = 4'h0;
   logic [7:0] req_header = 8'h00;
   logic [7:0] req_data = 8'h00;
   logic [7:0] rsp_data, rx_data, st, rd;
   logic req_ready, rsp_valid, busy, crystal_ready_n, crystal_off_state;
   logic rx_valid, overrun, b_rxv;
   logic [31:0] rnd = 32'h64cf;
   logic [7:0] mem [REG_COUNT];
   logic [7:0] wd [16];
   logic [7:0] fq [$];
   logic [7:0] rq [$];
   logic [7:0] eq [$];
   int failures = 0;
   int total_checks = 0;
   int last_t;
   int b_rx = 0;
   rcs_link_if lk ();
   rcs_link_if lk2 ();
   rcs_host i_rcs_host (.clock(clock), .rst_n(rst_n), .link(lk), .req_valid(req_valid),
      .req_header(req_header), .req_data(req_data), .req_last(req_last),
      .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .busy(busy));
   rcs_device i_rcs_device (.clock(clock), .rst_n(rst_n), .link(lk), .sleep_req(sleep_req),
      .chip_state(chip_state), .fifo_bytes(fifo_bytes), .crystal_ready_n(crystal_ready_n),
      .crystal_off_state(crystal_off_state), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .overrun(overrun));
   // Second device end, its link driven by the bench so framing can be broken
   rcs_device i_rcs_device_b (.clock(clock), .rst_n(rst_n), .link(lk2), .sleep_req(1'b0),
      .chip_state(chip_state), .fifo_bytes(fifo_bytes), .crystal_ready_n(),
      .crystal_off_state(), .rx_data(), .rx_valid(b_rxv), .rx_ready(1'b1), .overrun());
   rcs_link_monitor i_rcs_link_monitor (.clock(clock), .rst_n(rst_n),
      .chip_select_n(lk.chip_select_n), .sclk(lk.sclk), .mosi(lk.mosi),
      .miso_line(lk.miso_line), .crystal_ready_n(crystal_ready_n));
   always #5 clock = ~clock;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic test_done();
      if (failures == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic cyc();
      @(posedge clock);
      #1;
   endtask : cyc
   // Random drain, held off while a test stalls the far side
   always @(posedge clock) begin
      #1;
      rnd = lfsr(rnd);
      rx_ready = !stall && rnd[3];
   end
   // Capture of read data, FIFO output and second-end deliveries
   always @(posedge clock) begin
      if (rsp_valid === 1'b1) rq.push_back(rsp_data);
      if (b_rxv === 1'b1) b_rx++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) chk(rx_data, fq.pop_front());
   end
   task automatic frame(input logic [7:0] hdr, input int n);
      int k;
      int t;
      logic [5:0] a;
      a = hdr[5:0];
      rq.delete();
      eq.delete();
      chip_state = rnd[10:8];
      fifo_bytes = rnd[14:11];
      for (k = 0; k < n; k++) begin
         wd[k] = rnd[7:0] + 8'(k * 29);
         if (hdr[7]) eq.push_back(mem[a]);
         else begin
            mem[a] = wd[k];
            if (!stall || fq.size() < FIFO_DEPTH) fq.push_back(wd[k]); // Stalled: depth only
         end
         a = a + 6'(hdr[6]);
      end
      req_header = hdr;
      req_data = wd[0];
      req_last = (n == 1);
      req_valid = 1'b1;
      k = 0;
      for (t = 0; busy !== 1'b1 && t < 50; t++) cyc();
      req_valid = 1'b0;
      for (t = 0; busy === 1'b1 && t < 20000; t++) begin
         cyc();
         if (req_ready === 1'b1 && k < n - 1) begin
            k++;
            req_data = wd[k];
            req_last = (k == n - 1);
         end
      end
      last_t = t;
      repeat (2) cyc();
      chk({7'h0, busy}, 8'h00);
      if (hdr[7]) chk(8'(rq.size()), 8'(n));
      foreach (eq[i]) chk(rq[i], eq[i]);
   endtask : frame
   // Bench-made link clock of 80 ns, with a pause after each byte
   task automatic bb(input logic [7:0] o, input int nb, output logic [7:0] i);
      i = 8'h00;
      for (int b = 7; b > 7 - nb; b--) begin
         lk2.mosi = o[b];
         #40;
         lk2.sclk = 1'b1;
         i[b] = lk2.miso_line;
         #40;
         lk2.sclk = 1'b0;
      end
      #100;
   endtask : bb
   task automatic bf(input logic [7:0] h, input logic [7:0] d, input int nb);
      lk2.chip_select_n = 1'b0;
      for (int t = 0; lk2.miso_line !== 1'b0 && t < 50; t++) #10;
      bb(h, 8, st);
      bb(d, nb, rd);
      lk2.chip_select_n = 1'b1;
      #200;
   endtask : bf
   initial begin
      #500000;
      failures++;
      test_done();
   end
   initial begin
      lk2.chip_select_n = 1'b1;
      lk2.sclk = 1'b0;
      lk2.mosi = 1'b0;
      foreach (mem[i]) mem[i] = REG_RESET;
      repeat (4) @(posedge clock);
      #1;
      rst_n = 1'b1;
      cyc();
      frame(8'hc0, 4);
      frame(8'h05, 1);
      frame(8'h85, 1);
      frame(8'h50, 4);
      frame(8'hd0, 4);
      chk({7'h0, last_t < 2000}, 8'h01);
      sleep_req = 1'b1;
      repeat (20) cyc();
      chk({6'h0, crystal_off_state, crystal_ready_n}, 8'h03);
      frame(8'h90, 2);
      chk({7'h0, last_t > XTAL_START_CYC}, 8'h01);
      sleep_req = 1'b0;
      // Far side stalls so the FIFO fills and refuses
      stall = 1'b1;
      frame(8'h60, 12);
      chk({7'h0, overrun}, 8'h01);
      stall = 1'b0;
      repeat (200) cyc();
      chk(8'(fq.size()), 8'h00);
      frame(8'he0, 12);
      bf(8'h09, 8'ha5, 8);
      bf(8'h89, 8'h00, 8);
      chk(rd, 8'ha5);
      chk(st, {1'b0, chip_state, fifo_bytes});
      // Deselect after five data bits must drop the write
      bf(8'h09, 8'h3c, 5);
      bf(8'h89, 8'h00, 8);
      chk(rd, 8'ha5);
      chk(8'(b_rx), 8'h01);
      test_done();
   end
endmodule : tb
